// ==== src/ddr_interval_map.svh ====
// Purpose: Timing counts and field layout shared by both ends of the command interval link.
// Assumes: One 250 MHz clock; counts are in clock cycles of that clock.
// Notes: Each figure appears here once and is used by name.
// Functional notes
// - Read then write: terminate, wait, then write
// - Other row same bank: precharge, activate, write
// - Idle other bank may be opened during read
// - Write then read waits write_to_read_gap
// - Read other row: precharge after write gap
// - Idle other bank may be opened during write
// - Read interrupting write: mask one cycle before
// - Read right after write needs no mask
// - Other-row read cannot interrupt a write
// - Turnaround counts from edge after last pair
// - Terminate one or two cycles cuts write
// - Same-bank precharge interrupts the read burst
// - Full read needs precharge after half burst
// - Other-bank precharge leaves read undisturbed
// - Terminate floats data after read latency
// - Terminate during write stores nothing further
// - Precharge floats read data after read latency
// - Mask high blocks byte, zero latency
`ifndef DDR_INTERVAL_MAP_SVH
`define DDR_INTERVAL_MAP_SVH
`define READ_LATENCY_CYCLES 3
`define BURST_WORD_COUNT 4
`define WRITE_LATENCY_CYCLES 1
`define PRECHARGE_PERIOD_NS 15
`define ACTIVATE_TO_COLUMN_NS 15
`define WRITE_RECOVERY_NS 15
`define CLOCK_PERIOD_NS 4
`define PRECHARGE_PERIOD_CYC ((`PRECHARGE_PERIOD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define ACTIVATE_TO_COLUMN_CYC ((`ACTIVATE_TO_COLUMN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define WRITE_RECOVERY_CYC ((`WRITE_RECOVERY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define WRITE_TURNAROUND_CYC 1
`define BANK_COUNT 4
`define ROW_WIDTH 13
`define COL_WIDTH 10
`define DATA_WIDTH 16
`define BANK_WIDTH 2
`endif

// ==== src/ddr_interval_pkg.sv ====
// Purpose: Types shared by both ends of the command interval link.
// Assumes: The map header supplies widths.
// Notes: Command codes are one-hot so a decode is a single bit test.
`include "ddr_interval_map.svh"
package ddr_interval_pkg;
    typedef enum logic [6:0] {
        cmd_nop_type = 7'h01,
        cmd_read_type = 7'h02,
        cmd_write_type = 7'h04,
        cmd_activate_type = 7'h08,
        cmd_precharge_type = 7'h10,
        cmd_precharge_all_type = 7'h20,
        cmd_burst_terminate_type = 7'h40
    } command_type;
    typedef logic [`BANK_WIDTH-1:0] bank_type;
    typedef logic [`ROW_WIDTH-1:0] row_type;
    typedef logic [`DATA_WIDTH-1:0] data_type;
endpackage

// ==== src/ddr_interval_if.sv ====
// Purpose: Command, address and data wires between controller and memory end.
// Assumes: Commands are taken on the rising edge of clock.
// Notes: Data and strobe are modelled as one word per cycle with enables.
`timescale 1ns/1ps
interface ddr_interval_if (
    input wire logic clock
);
    import ddr_interval_pkg::*;
    command_type command;
    bank_type bank;
    row_type address;
    data_type data_from_controller;
    logic data_controller_oe;
    logic [1:0] write_byte_mask;
    data_type data_from_memory;
    logic data_memory_oe;
    logic data_strobe_out;
    logic data_strobe_oe;
    modport controller (
        input clock,
        output command,
        output bank,
        output address,
        output data_from_controller,
        output data_controller_oe,
        output write_byte_mask,
        input data_from_memory,
        input data_memory_oe,
        input data_strobe_out,
        input data_strobe_oe
    );
    modport memory (
        input clock,
        input command,
        input bank,
        input address,
        input data_from_controller,
        input data_controller_oe,
        input write_byte_mask,
        output data_from_memory,
        output data_memory_oe,
        output data_strobe_out,
        output data_strobe_oe
    );
endinterface

// ==== src/ddr_interval_memory.sv ====
// Purpose: Memory end: burst engine obeying terminate, precharge and byte mask.
// Assumes: The controller keeps all command spacing; bursts use burst_word_count.
// Notes: Storage is a small flip-flop array indexed by bank and column low bits.
`timescale 1ns/1ps
`include "ddr_interval_map.svh"
module ddr_interval_memory #(
    parameter int read_latency = `READ_LATENCY_CYCLES,
    parameter int burst_words = `BURST_WORD_COUNT
) (
    input wire logic clock,
    input wire logic rst_b,
    ddr_interval_if.memory link,
    output logic [`BANK_COUNT-1:0] bank_open,
    output logic write_stored
);
    import ddr_interval_pkg::*;
    localparam int depth = 64;
    data_type storage [0:depth-1];
    logic [5:0] rd_index;
    logic [5:0] wr_index;
    logic [3:0] rd_left;
    logic [3:0] wr_left;
    logic [1:0] rd_bank;
    logic [1:0] wr_bank;
    logic [7:0] float_pipe;
    logic [7:0] valid_pipe;
    logic [5:0] addr_pipe [0:7];
    logic [1:0] wr_lat;
    logic kill_read;

    ////////////////////////////////////////////////////////////////////////
    // Bank state follows activate and both precharge kinds.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            bank_open <= '0;
        else if (link.command == cmd_activate_type)
            bank_open[link.bank] <= 1'b1;
        else if (link.command == cmd_precharge_all_type)
            bank_open <= '0;
        else if (link.command == cmd_precharge_type)
            bank_open[link.bank] <= 1'b0;
    end

    // A terminate, or a precharge aimed at the reading bank, ends the read.
    always_comb
    begin
        kill_read = (link.command == cmd_burst_terminate_type)
            || (link.command == cmd_precharge_all_type)
            || (link.command == cmd_precharge_type && link.bank == rd_bank);
    end

    ////////////////////////////////////////////////////////////////////////
    // Read burst sequencer; a new read restarts it, a kill stops issuing words.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_left <= '0;
            rd_index <= '0;
            rd_bank <= '0;
        end
        else if (link.command == cmd_read_type)
        begin
            rd_left <= 4'(burst_words / 2 - 1); // The command edge fetches the first word.
            rd_index <= {link.bank, link.address[3:0]} + 6'h2;
            rd_bank <= link.bank;
        end
        else if (kill_read && rd_left != 0)
            rd_left <= '0;
        else if (rd_left != 0)
        begin
            rd_left <= rd_left - 4'h1;
            rd_index <= rd_index + 6'h2;
        end
    end

    // Latency pipe: a word appears read_latency cycles after being fetched.
    // Words already in flight drain, so the pins float exactly latency cycles after the kill.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            valid_pipe <= '0;
            float_pipe <= '0;
            for (int i = 0; i < 8; i++)
                addr_pipe[i] <= '0;
        end
        else
        begin
            valid_pipe <= {valid_pipe[6:0], (rd_left != 0 && !kill_read) || link.command == cmd_read_type};
            float_pipe <= {float_pipe[6:0], kill_read};
            addr_pipe[0] <= (link.command == cmd_read_type) ? {link.bank, link.address[3:0]} : rd_index;
            for (int i = 1; i < 8; i++)
                addr_pipe[i] <= addr_pipe[i-1];
        end
    end

    // Outputs are registered; float follows the kill by read latency.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            link.data_memory_oe <= 1'b0;
            link.data_strobe_oe <= 1'b0;
            link.data_strobe_out <= 1'b0;
            link.data_from_memory <= '0;
        end
        else
        begin
            link.data_memory_oe <= valid_pipe[read_latency-2] && !float_pipe[read_latency-2];
            link.data_strobe_oe <= valid_pipe[read_latency-2] && !float_pipe[read_latency-2];
            link.data_strobe_out <= valid_pipe[read_latency-2];
            link.data_from_memory <= storage[addr_pipe[read_latency-2]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write burst: data follows the command by write latency; a terminate or read stops it.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_left <= '0;
            wr_lat <= '0;
            wr_index <= '0;
            wr_bank <= '0;
        end
        else if (link.command == cmd_write_type)
        begin
            wr_left <= 4'(burst_words / 2);
            wr_lat <= 2'(`WRITE_LATENCY_CYCLES - 1);
            wr_index <= {link.bank, link.address[3:0]};
            wr_bank <= link.bank;
        end
        else if (link.command == cmd_burst_terminate_type || link.command == cmd_read_type)
            wr_left <= '0;
        else if (wr_lat != 0)
            wr_lat <= wr_lat - 2'h1;
        else if (wr_left != 0)
        begin
            wr_left <= wr_left - 4'h1;
            wr_index <= wr_index + 6'h2;
        end
    end

    // Byte lanes with the mask high keep their old contents, no delay.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < depth; i++)
                storage[i] <= '0;
            write_stored <= 1'b0;
        end
        else
        begin
            write_stored <= 1'b0;
            if (wr_lat == 0 && wr_left != 0 && link.command != cmd_burst_terminate_type
                && link.data_controller_oe)
            begin
                write_stored <= ~&link.write_byte_mask;
                if (!link.write_byte_mask[0])
                    storage[wr_index][7:0] <= link.data_from_controller[7:0];
                if (!link.write_byte_mask[1])
                    storage[wr_index][15:8] <= link.data_from_controller[15:8];
            end
        end
    end
endmodule

// ==== src/ddr_interval_controller.sv ====
// Purpose: Controller end: picks the legal interval sequence for each request.
// Assumes: One request at a time, taken when ready is high.
// Notes: Read-to-read and write-to-write spacing are outside this end.
`timescale 1ns/1ps
`include "ddr_interval_map.svh"
module ddr_interval_controller #(
    parameter int read_latency = `READ_LATENCY_CYCLES,
    parameter int burst_words = `BURST_WORD_COUNT
) (
    input wire logic clock,
    input wire logic rst_b,
    ddr_interval_if.controller link,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_interrupt,
    input wire ddr_interval_pkg::bank_type req_bank,
    input wire ddr_interval_pkg::row_type req_row,
    input wire ddr_interval_pkg::data_type req_data,
    output logic req_ready
);
    import ddr_interval_pkg::*;
    typedef enum logic [5:0] {
        st_idle_type = 6'h01,
        st_gap_type = 6'h02,
        st_pre_type = 6'h04,
        st_act_type = 6'h08,
        st_col_type = 6'h10,
        st_data_type = 6'h20
    } state_type;
    state_type state;
    logic [`BANK_COUNT-1:0] active;
    row_type open_row [0:`BANK_COUNT-1];
    logic last_write;
    logic busy_burst;
    bank_type last_bank;
    logic [7:0] wait_count;
    logic [3:0] data_left;
    logic hold_write;
    logic hold_interrupt;
    bank_type hold_bank;
    row_type hold_row;

    // Gap needed after the previous column command before the new one.
    function automatic logic [7:0] column_gap(input logic prev_write, input logic now_write,
        input logic cut);
        if (!prev_write && now_write)
            column_gap = 8'(read_latency + 1); // stop_to_write_gap >= stop_to_float_delay
        else if (prev_write && !now_write)
            column_gap = cut ? 8'h1 : 8'(`WRITE_LATENCY_CYCLES + burst_words / 2 + `WRITE_TURNAROUND_CYC);
        else
            column_gap = 8'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: terminate or wait, precharge, activate, column command.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= st_idle_type;
            link.command <= cmd_nop_type;
            link.bank <= '0;
            link.address <= '0;
            wait_count <= '0;
            req_ready <= 1'b1;
            hold_write <= 1'b0;
            hold_interrupt <= 1'b0;
            hold_bank <= '0;
            hold_row <= '0;
        end
        else
        begin
            link.command <= cmd_nop_type;
            if (wait_count != 0)
                wait_count <= wait_count - 8'h1;
            case (state)
                st_idle_type:
                    if (req_valid && req_ready)
                    begin
                        req_ready <= 1'b0;
                        hold_write <= req_write;
                        hold_interrupt <= req_interrupt;
                        hold_bank <= req_bank;
                        hold_row <= req_row;
                        link.bank <= req_bank;
                        if (!active[req_bank] || open_row[req_bank] != req_row)
                        begin
                            // Other row or idle bank: precharge path, read left alone elsewhere.
                            state <= st_pre_type;
                            if (last_write && busy_burst && last_bank == req_bank)
                                wait_count <= 8'(`WRITE_LATENCY_CYCLES + burst_words / 2 + `WRITE_RECOVERY_CYC);
                            else if (!last_write && busy_burst && last_bank == req_bank)
                                wait_count <= 8'(burst_words / 2);
                        end
                        else if (!last_write && busy_burst && req_write)
                        begin
                            link.command <= cmd_burst_terminate_type;
                            wait_count <= column_gap(1'b0, 1'b1, 1'b0);
                            state <= st_gap_type;
                        end
                        else
                        begin
                            wait_count <= busy_burst ? column_gap(last_write, req_write, req_interrupt) : 8'h0;
                            state <= st_gap_type;
                        end
                    end
                st_pre_type:
                    if (wait_count == 0)
                    begin
                        link.command <= cmd_precharge_type;
                        wait_count <= 8'(`PRECHARGE_PERIOD_CYC);
                        state <= st_act_type;
                    end
                st_act_type:
                    if (wait_count <= 1)
                    begin
                        link.command <= cmd_activate_type;
                        link.address <= hold_row;
                        wait_count <= 8'(`ACTIVATE_TO_COLUMN_CYC);
                        state <= st_gap_type;
                    end
                st_gap_type:
                    if (wait_count <= 1)
                        state <= st_col_type;
                st_col_type:
                begin
                    link.command <= hold_write ? cmd_write_type : cmd_read_type;
                    link.address <= '0;
                    state <= hold_write ? st_data_type : st_idle_type;
                    req_ready <= !hold_write;
                end
                st_data_type:
                    if (data_left == 1)
                    begin
                        state <= st_idle_type;
                        req_ready <= 1'b1;
                    end
                default:
                    state <= st_idle_type;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bank and row bookkeeping so each request picks its case.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            active <= '0;
            for (int i = 0; i < `BANK_COUNT; i++)
                open_row[i] <= '0;
        end
        else if (link.command == cmd_activate_type)
        begin
            active[link.bank] <= 1'b1;
            open_row[link.bank] <= link.address;
        end
        else if (link.command == cmd_precharge_type)
            active[link.bank] <= 1'b0;
    end

    // Remembers the last column command; busy until a terminate or precharge follows.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            last_write <= 1'b0;
            last_bank <= '0;
            busy_burst <= 1'b0;
        end
        else if (link.command == cmd_read_type || link.command == cmd_write_type)
        begin
            last_write <= link.command == cmd_write_type;
            last_bank <= link.bank;
            busy_burst <= 1'b1;
        end
        else if (link.command == cmd_burst_terminate_type || link.command == cmd_precharge_type)
            busy_burst <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write data drive; a requested interrupt masks the last word of the burst.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_left <= '0;
            link.data_from_controller <= '0;
            link.data_controller_oe <= 1'b0;
            link.write_byte_mask <= 2'h0;
        end
        else if (link.command == cmd_write_type)
        begin
            data_left <= 4'(burst_words / 2);
            link.data_from_controller <= req_data;
            link.data_controller_oe <= 1'b1;
            link.write_byte_mask <= 2'h0;
        end
        else if (data_left != 0)
        begin
            data_left <= data_left - 4'h1;
            link.data_controller_oe <= data_left != 1;
            link.write_byte_mask <= (hold_interrupt && data_left == 2) ? 2'h3 : 2'h0;
        end
        else
        begin
            link.data_controller_oe <= 1'b0;
            link.write_byte_mask <= 2'h0;
        end
    end
endmodule

// ==== verif/ddr_interval_assertions.sv ====
// Purpose: Interval checks on the command link between the two ends.
// Assumes: Read latency 3, four words a burst, 4 ns clock, so 4-cycle row gaps.
// Notes: Gaps are plain repetition counts; helper logic tracks banks and write age.
`timescale 1ns/1ps
module ddr_interval_assertions (
    input wire logic clock,
    input wire logic rst_b,
    input wire ddr_interval_pkg::command_type command,
    input wire ddr_interval_pkg::bank_type bank,
    input wire logic [1:0] write_byte_mask,
    input wire logic data_memory_oe,
    input wire logic data_strobe_oe
);
    import ddr_interval_pkg::*;
    bank_type read_bank;
    bank_type write_bank;
    logic [3:0] since_write;
    logic stop;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    // Banks of the last read and write, so precharges can be matched to them.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            read_bank <= 2'h0;
            write_bank <= 2'h0;
        end
        else
        begin
            if (command == cmd_read_type) read_bank <= bank;
            if (command == cmd_write_type) write_bank <= bank;
        end
    end
    // Age of the last write; it saturates so an old write never looks recent.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b) since_write <= 4'hf;
        else if (command == cmd_write_type) since_write <= 4'h1;
        else if (since_write != 4'hf) since_write <= since_write + 4'h1;
    end
    // Anything that may cut a read short.
    assign stop = command == cmd_burst_terminate_type || command == cmd_precharge_all_type
        || (command == cmd_precharge_type && bank == read_bank);
    ////////////////////////////////////////////////////////////////////////
    a_full_read_burst: assert property ((command == cmd_read_type) ##1 !stop ##1 !stop
        |-> ##1 data_memory_oe ##1 data_memory_oe) else $error("read burst cut short");
    a_terminate_floats: assert property ((command == cmd_burst_terminate_type)
        |-> ##3 !data_memory_oe && !data_strobe_oe) else $error("data not floated after terminate");
    a_precharge_floats: assert property ((command == cmd_precharge_all_type ||
        (command == cmd_precharge_type && bank == read_bank)) |-> ##3 !data_memory_oe)
        else $error("data not floated after precharge");
    a_mask_before_read: assert property ((command == cmd_read_type && since_write inside {[2:3]})
        |-> $past(write_byte_mask) == 2'h3) else $error("write tail not masked before read");
    a_write_precharge_gap: assert property ((command == cmd_precharge_type && bank == write_bank)
        |-> since_write >= 4'h7) else $error("precharge too soon after write");
    a_stop_write_gap: assert property ((command == cmd_burst_terminate_type)
        |=> (command != cmd_write_type) [*3]) else $error("write too soon after terminate");
    a_precharge_period: assert property ((command == cmd_precharge_type ||
        command == cmd_precharge_all_type) |=> (command != cmd_activate_type) [*3])
        else $error("activate too soon after precharge");
    a_activate_column_gap: assert property ((command == cmd_activate_type)
        |=> (command != cmd_read_type && command != cmd_write_type) [*3])
        else $error("column command too soon after activate");
    c_read: cover property (command == cmd_read_type);
    c_terminate: cover property (command == cmd_burst_terminate_type);
    c_activate: cover property (command == cmd_activate_type);
    c_masked_read: cover property (command == cmd_read_type && since_write inside {[2:3]});
endmodule

// ==== verif/ddr_interval_tb.sv ====
// Purpose: Drives the controller user side and judges what the memory end returns.
// Assumes: Both ends keep the hand-over timing; one request in flight at a time.
// Notes: Read data is judged by the first word of each burst.
`timescale 1ns/1ps
`include "ddr_interval_map.svh"
module ddr_interval_tb;
    import ddr_interval_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_interrupt = 1'b0;
    bank_type req_bank = 2'h0;
    row_type req_row = 13'h0000;
    data_type req_data = 16'h0000;
    logic req_ready;
    logic [`BANK_COUNT-1:0] bank_open;
    logic write_stored;
    logic oe_prev = 1'b0;
    data_type first_word;
    int read_bursts = 0;
    int stored = 0;
    int fails = 0;
    int checks = 0;
    always #2 clock = ~clock;
    ddr_interval_if ddr_interval_if_i (.clock(clock));
    ddr_interval_memory ddr_interval_memory_i (.clock(clock), .rst_b(rst_b), .link(ddr_interval_if_i),
        .bank_open(bank_open), .write_stored(write_stored));
    ddr_interval_controller ddr_interval_controller_i (.clock(clock), .rst_b(rst_b), .link(ddr_interval_if_i),
        .req_valid(req_valid), .req_write(req_write), .req_interrupt(req_interrupt), .req_bank(req_bank),
        .req_row(req_row), .req_data(req_data), .req_ready(req_ready));
    ddr_interval_assertions ddr_interval_assertions_i (.clock(clock), .rst_b(rst_b),
        .command(ddr_interval_if_i.command), .bank(ddr_interval_if_i.bank),
        .write_byte_mask(ddr_interval_if_i.write_byte_mask), .data_memory_oe(ddr_interval_if_i.data_memory_oe),
        .data_strobe_oe(ddr_interval_if_i.data_strobe_oe));
    ////////////////////////////////////////////////////////////////////////
    // Catch the first word of each burst and count stored words.
    always @(posedge clock)
    begin
        if (ddr_interval_if_i.data_memory_oe === 1'b1 && oe_prev !== 1'b1)
        begin
            first_word = ddr_interval_if_i.data_from_memory;
            read_bursts++;
        end
        oe_prev = ddr_interval_if_i.data_memory_oe;
        if (write_stored === 1'b1) stored++;
    end
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic compare_word(input string name, input data_type exp, input data_type got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic compare_count(input string name, input int exp, input int got);
        checks++;
        if (got != exp)
        begin
            fails++;
            $display("Error %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic compare_flag(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    // Bounded wait on a condition sampled at falling edges, clear of update races.
    task automatic wait_until(input bit for_read, input int start);
        int n;
        n = 0;
        @(negedge clock);
        while (for_read ? read_bursts <= start : req_ready !== 1'b1)
        begin
            n++;
            if (n > 300)
            begin
                fails++;
                $display("Error wait expected done seen timeout");
                stop_test();
            end
            @(negedge clock);
        end
    endtask
    // One request: raised after an edge, held until the edge that takes it.
    task automatic do_req(input logic wr, input logic cut, input bank_type b, input row_type r, input data_type d);
        wait_until(1'b0, 0);
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= wr;
        req_interrupt <= cut;
        req_bank <= b;
        req_row <= r;
        req_data <= d;
        @(posedge clock);
        req_valid <= 1'b0;
        wait_until(1'b0, 0);
    endtask
    task automatic read_back(input bank_type b, input row_type r, output data_type got);
        int start;
        start = read_bursts;
        do_req(1'b0, 1'b0, b, r, 16'h0000);
        wait_until(1'b1, start);
        got = first_word;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_write_read();
        data_type got;
        int s0;
        s0 = stored;
        do_req(1'b1, 1'b0, 2'h0, 13'h0001, 16'h1234);
        read_back(2'h0, 13'h0001, got);
        compare_word("write then read", 16'h1234, got);
        compare_count("words stored", 2, stored - s0);
        compare_flag("bank 0 open", 1'b1, bank_open[0]);
        $display("test_write_read done");
    endtask
    // A write straight after a read has to terminate the burst first.
    task automatic test_read_write();
        data_type got;
        read_back(2'h0, 13'h0001, got);
        do_req(1'b1, 1'b0, 2'h0, 13'h0001, 16'h5678);
        read_back(2'h0, 13'h0001, got);
        compare_word("read then write", 16'h5678, got);
        $display("test_read_write done");
    endtask
    task automatic test_row_change();
        data_type got;
        do_req(1'b1, 1'b0, 2'h0, 13'h0002, 16'habcd);
        read_back(2'h0, 13'h0003, got);
        read_back(2'h0, 13'h0002, got);
        compare_word("row change", 16'habcd, got);
        $display("test_row_change done");
    endtask
    task automatic test_idle_bank();
        data_type got;
        do_req(1'b1, 1'b0, 2'h2, 13'h0005, 16'h0f0f);
        read_back(2'h3, 13'h0004, got);
        compare_flag("bank 3 open", 1'b1, bank_open[3]);
        do_req(1'b1, 1'b0, 2'h1, 13'h0006, 16'h2468);
        read_back(2'h1, 13'h0006, got);
        compare_word("idle bank write", 16'h2468, got);
        read_back(2'h2, 13'h0005, got);
        compare_word("bank kept", 16'h0f0f, got);
        $display("test_idle_bank done");
    endtask
    // The masked tail of a cut write must not be stored.
    task automatic test_interrupt();
        data_type got;
        int s0;
        s0 = stored;
        do_req(1'b1, 1'b1, 2'h1, 13'h0006, 16'h9999);
        read_back(2'h1, 13'h0006, got);
        compare_count("words stored cut", 1, stored - s0);
        compare_word("cut write head", 16'h9999, got);
        $display("test_interrupt done");
    endtask
    initial
    begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        test_write_read();
        test_read_write();
        test_row_change();
        test_idle_bank();
        test_interrupt();
        stop_test();
    end
endmodule
